// ---- hdl/ssb_serial.sv ----
`timescale 1ns/100ps
module ssb_serial (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic autobaud_rx,
  output logic async_rx_data,
  output logic baud_clk_tick,
  output logic tx_buffer_irq,
  output logic tx_done_irq,
  output logic rx_irq,
  output logic error_irq
);

  ssb_pkg::ssb_ctrl_s control_reg;
  logic [7:0] tx_buffer;
  logic [7:0] rx_buffer;
  logic [12:0] reload_value;
  logic [8:0] frac_div_value;
  logic [12:0] timer_count;
  logic tx_full;
  logic rx_full;
  logic overrun_flag;
  logic reload_req;
  logic brt_tick;
  logic baud_tick;

  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic rd_rxbuf;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  ssb_pkg::ssb_state_e state;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt;
  logic [1:0] phase;
  logic is_tx;
  logic is_rx;
  logic sclk;
  logic sdata;
  logic byte_done;
  logic sync_mode;
  logic rx_inv;
  logic async_tx;
  logic next_txd;
  logic next_rxd;
  logic next_oe;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = nv[i*8 +: 8];
    return res;
  endfunction : merge

  assign sync_mode = (control_reg.mode_field == ssb_pkg::MODE_SYNC);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_ok = (aw_addr == ssb_pkg::OFS_CTRL) || (aw_addr == ssb_pkg::OFS_TXBUF) ||
                 (aw_addr == ssb_pkg::OFS_BAUD) || (aw_addr == ssb_pkg::OFS_FDIV) ||
                 (aw_addr == ssb_pkg::OFS_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssb_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ssb_pkg::RESP_OKAY : ssb_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb
  begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      ssb_pkg::OFS_CTRL: rd_val = 32'(control_reg);
      ssb_pkg::OFS_TXBUF: rd_val = 32'(tx_buffer);
      ssb_pkg::OFS_RXBUF: rd_val = 32'(rx_buffer);
      ssb_pkg::OFS_BAUD: rd_val = 32'(timer_count);
      ssb_pkg::OFS_FDIV: rd_val = 32'(frac_div_value);
      ssb_pkg::OFS_STAT:
      begin
        rd_val = 32'h0000_0000;
        rd_val[ssb_pkg::STAT_OVR_BIT] = overrun_flag;
        rd_val[ssb_pkg::STAT_TXFULL_BIT] = tx_full;
        rd_val[ssb_pkg::STAT_RXFULL_BIT] = rx_full;
        rd_val[ssb_pkg::STAT_BUSY_BIT] = (state != ssb_pkg::ST_IDLE);
      end
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign rd_rxbuf = s_axi_arvalid && s_axi_arready &&
                    ({s_axi_araddr[7:2], 2'b00} == ssb_pkg::OFS_RXBUF);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ssb_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? ssb_pkg::RESP_OKAY : ssb_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg <= ssb_pkg::RST_CTRL;
      tx_buffer <= 8'h00;
      reload_value <= ssb_pkg::RST_RELOAD;
      frac_div_value <= ssb_pkg::RST_FDIV;
      reload_req <= 1'b0;
    end
    else
    begin
      reload_req <= 1'b0;
      if (byte_done && is_rx)
        control_reg.rx_enable <= 1'b0;
      if (do_write)
      begin
        case (aw_addr)
          ssb_pkg::OFS_CTRL:
            control_reg <= ssb_pkg::ssb_ctrl_s'(13'(merge(32'(control_reg), w_data, w_strb)));
          ssb_pkg::OFS_TXBUF:
            if (w_strb[0])
              tx_buffer <= w_data[7:0];
          ssb_pkg::OFS_BAUD:
          begin
            reload_value <= 13'(merge(32'(reload_value), w_data, w_strb));
            reload_req <= 1'b1;
          end
          ssb_pkg::OFS_FDIV:
            frac_div_value <= 9'(merge(32'(frac_div_value), w_data, w_strb));
          default: ;
        endcase
      end
    end
  end

  ssb_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .baud_run(control_reg.baud_run),
    .sync_mode(sync_mode),
    .prescale_sel(control_reg.prescale_sel),
    .frac_div_en(control_reg.frac_div_en),
    .frac_div_value(frac_div_value),
    .reload_value(reload_value),
    .reload_req(reload_req),
    .timer_count(timer_count),
    .brt_tick(brt_tick),
    .baud_tick(baud_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Synchronous shift engine
  assign byte_done = (state == ssb_pkg::ST_SHIFT) && brt_tick && (phase == 2'h3) &&
                     (bit_cnt == 3'(ssb_pkg::BITS_PER_BYTE - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ssb_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt <= 3'h0;
      phase <= 2'h0;
      is_tx <= 1'b0;
      is_rx <= 1'b0;
      sclk <= 1'b1;
      sdata <= 1'b1;
      tx_buffer_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_buffer_irq <= 1'b0;
      tx_done_irq <= 1'b0;
      rx_irq <= 1'b0;
      case (state)
        ssb_pkg::ST_IDLE:
        begin
          sclk <= 1'b1;
          sdata <= 1'b1;
          phase <= 2'h0;
          bit_cnt <= 3'h0;
          if (sync_mode && control_reg.baud_run)
          begin
            if (tx_full && (!control_reg.rx_enable || control_reg.loopback_sel))
            begin
              shift_reg <= tx_buffer;
              tx_buffer_irq <= 1'b1;
              is_tx <= 1'b1;
              is_rx <= control_reg.rx_enable;
              state <= ssb_pkg::ST_SHIFT;
            end
            else if (control_reg.rx_enable)
            begin
              is_tx <= 1'b0;
              is_rx <= 1'b1;
              state <= ssb_pkg::ST_SHIFT;
            end
          end
        end
        ssb_pkg::ST_SHIFT:
          if (brt_tick)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0:
              begin
                sclk <= 1'b0;
                if (is_tx)
                  sdata <= shift_reg[0];
              end
              2'h2:
              begin
                sclk <= 1'b1;
                shift_reg <= {control_reg.loopback_sel ? sdata : rxd_in, shift_reg[7:1]};
              end
              2'h3:
                if (byte_done)
                begin
                  sdata <= 1'b1;
                  tx_done_irq <= is_tx;
                  rx_irq <= is_rx;
                  state <= ssb_pkg::ST_GAP;
                end
                else
                  bit_cnt <= bit_cnt + 3'h1;
              default: ;
            endcase
          end
        ssb_pkg::ST_GAP:
          if (brt_tick)
          begin
            phase <= phase + 2'h1;
            if (phase == 2'(ssb_pkg::SYNC_BAUD_DIV - 1))
              state <= ssb_pkg::ST_IDLE;
          end
        default: state <= ssb_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer flags and overrun
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_full <= 1'b0;
      rx_full <= 1'b0;
      overrun_flag <= 1'b0;
      rx_buffer <= 8'h00;
      error_irq <= 1'b0;
    end
    else
    begin
      error_irq <= 1'b0;
      if (do_write && aw_addr == ssb_pkg::OFS_TXBUF && w_strb[0])
        tx_full <= 1'b1;
      else if (state == ssb_pkg::ST_IDLE && tx_buffer_irq == 1'b0 && sync_mode &&
               control_reg.baud_run && tx_full &&
               (!control_reg.rx_enable || control_reg.loopback_sel))
        tx_full <= 1'b0;
      if (byte_done && is_rx)
      begin
        rx_buffer <= shift_reg;
        rx_full <= 1'b1;
        if (rx_full && !rd_rxbuf && control_reg.overrun_check_en)
        begin
          error_irq <= 1'b1;
          overrun_flag <= 1'b1;
        end
      end
      else if (rd_rxbuf)
        rx_full <= 1'b0;
      if (do_write && aw_addr == ssb_pkg::OFS_STAT && w_strb[0] &&
          w_data[ssb_pkg::STAT_OVR_BIT] && !(byte_done && is_rx && rx_full))
        overrun_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin data path
  assign rx_inv = rxd_in ^ control_reg.rx_invert_sel;
  assign async_tx = 1'b1;

  always_comb
  begin
    if (sync_mode)
    begin
      next_txd = sclk;
      next_rxd = sdata;
      next_oe = is_tx && (state != ssb_pkg::ST_IDLE);
    end
    else
    begin
      next_txd = (control_reg.echo_mode_sel ? rx_inv : async_tx) ^
                 control_reg.tx_invert_sel;
      next_rxd = 1'b1;
      next_oe = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      autobaud_rx <= 1'b1;
      async_rx_data <= 1'b1;
      baud_clk_tick <= 1'b0;
    end
    else
    begin
      txd_out <= next_txd;
      rxd_out <= next_rxd;
      rxd_oe <= next_oe;
      autobaud_rx <= rx_inv;
      async_rx_data <= (control_reg.loopback_sel ? async_tx : rx_inv) ^
                       control_reg.irda_rx_invert_sel;
      baud_clk_tick <= baud_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sclk_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ssb_pkg::ST_IDLE |=> sclk)
    else $error("shift clock not high when idle");

  tx_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ssb_pkg::ST_IDLE && sync_mode && control_reg.baud_run && tx_full &&
    !control_reg.rx_enable |=> tx_buffer_irq && state == ssb_pkg::ST_SHIFT)
    else $error("transmit did not start");

  byte_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && is_tx |=> tx_done_irq && sdata && state == ssb_pkg::ST_GAP)
    else $error("transmit end wrong");

  rx_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && is_rx && !do_write |=> rx_irq && !control_reg.rx_enable && rx_full)
    else $error("receive end wrong");

  overrun_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && is_rx && rx_full && !rd_rxbuf && control_reg.overrun_check_en
    |=> error_irq && overrun_flag)
    else $error("overrun missed");

  gap_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ssb_pkg::ST_GAP) |-> state == ssb_pkg::ST_GAP [*4])
    else $error("byte gap too short");

  rx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ssb_pkg::ST_SHIFT && is_rx && !is_tx |=> !tx_buffer_irq)
    else $error("transmit started during reception");

  echo_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sync_mode && control_reg.echo_mode_sel && $stable(control_reg) |=>
    txd_out == ($past(rxd_in) ^ $past(control_reg.rx_invert_sel) ^
                $past(control_reg.tx_invert_sel)))
    else $error("echo path wrong");

  baud_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == ssb_pkg::OFS_BAUD
    |=> s_axi_rdata[15:13] == 3'h0 && s_axi_rvalid)
    else $error("baud read upper bits set");

endmodule : ssb_serial

// ---- hdl/ssb_pkg.sv ----
package ssb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXBUF = 8'h04;
  localparam logic [7:0] OFS_RXBUF = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_FDIV = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // Field widths and positions
  localparam int TIMER_W = 13;
  localparam int FDIV_W = 9;
  localparam int DATA_W = 8;
  localparam int STAT_OVR_BIT = 0;
  localparam int STAT_TXFULL_BIT = 1;
  localparam int STAT_RXFULL_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // Mode encoding
  localparam logic [2:0] MODE_SYNC = 3'h0;

  // Counts
  localparam int BITS_PER_BYTE = 8;
  localparam int ASYNC_BAUD_DIV = 16;
  localparam int SYNC_BAUD_DIV = 4;
  localparam int PRESC_DIV_LO = 2;
  localparam int PRESC_DIV_HI = 3;

  // Reset values
  localparam logic [12:0] RST_RELOAD = 13'h0000;
  localparam logic [8:0] RST_FDIV = 9'h000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register, bit 0 upward from mode_field
  typedef struct packed {
    logic frac_div_en;
    logic prescale_sel;
    logic overrun_check_en;
    logic irda_rx_invert_sel;
    logic tx_invert_sel;
    logic rx_invert_sel;
    logic echo_mode_sel;
    logic loopback_sel;
    logic rx_enable;
    logic baud_run;
    logic [2:0] mode_field;
  } ssb_ctrl_s;

  localparam ssb_ctrl_s RST_CTRL = '0;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} ssb_state_e;

endpackage : ssb_pkg

// ---- hdl/ssb_baud_gen.sv ----
`timescale 1ns/100ps
module ssb_baud_gen #(
  parameter int TW = ssb_pkg::TIMER_W,
  parameter int FW = ssb_pkg::FDIV_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic baud_run,
  input wire logic sync_mode,
  input wire logic prescale_sel,
  input wire logic frac_div_en,
  input wire logic [FW-1:0] frac_div_value,
  input wire logic [TW-1:0] reload_value,
  input wire logic reload_req,
  output logic [TW-1:0] timer_count,
  output logic brt_tick,
  output logic baud_tick
);

  logic [1:0] presc_cnt;
  logic [FW-1:0] frac_acc;
  logic [FW:0] frac_sum;
  logic div_tick;
  logic reload_pend;
  logic [3:0] baud_cnt;
  logic frac_on;

  assign frac_on = frac_div_en && !sync_mode;
  assign frac_sum = {1'b0, frac_acc} + {1'b0, frac_div_value};

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_comb
  begin
    if (frac_on)
      div_tick = (frac_div_value == '0) || frac_sum[FW];
    else if (prescale_sel)
      div_tick = (presc_cnt == 2'(ssb_pkg::PRESC_DIV_HI - 1));
    else
      div_tick = (presc_cnt == 2'(ssb_pkg::PRESC_DIV_LO - 1));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !baud_run)
    begin
      presc_cnt <= 2'h0;
      frac_acc <= '0;
    end
    else
    begin
      presc_cnt <= div_tick ? 2'h0 : presc_cnt + 2'h1;
      frac_acc <= frac_on ? frac_sum[FW-1:0] : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reloadable down counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_count <= '0;
      reload_pend <= 1'b0;
      brt_tick <= 1'b0;
    end
    else
    begin
      brt_tick <= 1'b0;
      if (!baud_run)
      begin
        if (reload_req)
          reload_pend <= 1'b1;
      end
      else if (reload_req || reload_pend)
      begin
        timer_count <= reload_value;
        reload_pend <= 1'b0;
      end
      else if (div_tick)
      begin
        if (timer_count == '0)
        begin
          timer_count <= reload_value;
          brt_tick <= 1'b1;
        end
        else
          timer_count <= timer_count - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud clock divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !baud_run)
    begin
      baud_cnt <= 4'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      baud_tick <= 1'b0;
      if (brt_tick)
      begin
        if ((sync_mode && baud_cnt == 4'(ssb_pkg::SYNC_BAUD_DIV - 1)) ||
            (!sync_mode && baud_cnt == 4'(ssb_pkg::ASYNC_BAUD_DIV - 1)))
        begin
          baud_cnt <= 4'h0;
          baud_tick <= 1'b1;
        end
        else
          baud_cnt <= baud_cnt + 4'h1;
      end
    end
  end

  timer_stops_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !baud_run && !$past(reload_req) |=> $stable(timer_count))
    else $error("timer moved while stopped");

  baud_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
    baud_tick |-> $past(brt_tick))
    else $error("baud tick without underflow");

endmodule : ssb_baud_gen

// ---- verif/ssb_shift_dev.sv ----
`timescale 1ns/100ps
module ssb_shift_dev (
  input wire logic sck,
  input wire logic rst_n,
  input wire logic line,
  input wire logic [7:0] tx_val,
  output logic drive,
  output logic [7:0] got
);
  logic [2:0] idx;
  // Next bit out, LSB first, advanced after each sample
  assign drive = tx_val[idx];
  always @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx <= 3'h0;
      got <= 8'h00;
    end
    else
    begin
      idx <= idx + 3'h1;
      got <= {line, got[7:1]};
    end
  end
endmodule : ssb_shift_dev

// ---- verif/tb_ssb_serial.sv ----
`timescale 1ns/100ps
module tb_ssb_serial;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rxd_out, rxd_oe, txd_out, autobaud_rx, async_rx_data, baud_clk_tick;
  logic tx_buffer_irq, tx_done_irq, rx_irq, error_irq;
  logic ovr_en = 1'b0, ovr = 1'b1, dev_bit;
  logic [7:0] dev_val = 8'h3c, dev_got;
  wire logic rxd_in;
  wire logic [4:0] irqs;
  int bad_count = 0, checks_done = 0;
  logic [31:0] d;
  logic [1:0] r;
  assign irqs = {baud_clk_tick, error_irq, rx_irq, tx_done_irq, tx_buffer_irq};
  // Receive wire: module, bench override, or partner
  assign rxd_in = rxd_oe ? rxd_out : (ovr_en ? ovr : dev_bit);
  always #12.5 aclk = ~aclk;
  ssb_serial DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_in, .rxd_out, .rxd_oe, .txd_out,
    .autobaud_rx, .async_rx_data, .baud_clk_tick, .tx_buffer_irq, .tx_done_irq, .rx_irq,
    .error_irq);
  // Partner held idle while the bench overrides the receive wire
  ssb_shift_dev dev (.sck(txd_out), .rst_n(aresetn && !ovr_en), .line(rxd_in), .tx_val(dev_val),
    .drive(dev_bit), .got(dev_got));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Pass when the chosen event pulses within lim cycles
  task wait_irq(input int sel, input int lim);
    bit hit;
    hit = 0;
    for (int n = 0; n < lim && !hit; n++)
    begin
      @(posedge aclk);
      hit = (irqs[sel] === 1'b1);
    end
    chk({31'h0, hit}, 32'h1);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [7:0] ofs [4];
    ofs = '{ssb_pkg::OFS_CTRL, ssb_pkg::OFS_BAUD, ssb_pkg::OFS_FDIV, ssb_pkg::OFS_STAT};
    foreach (ofs[i])
    begin
      axi_rd(ofs[i], d, r);
      chk(d, 32'h0);
    end
    axi_rd(8'h18, d, r);
    chk({30'h0, r}, {30'h0, ssb_pkg::RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset
  task t_echo;
    ovr_en <= 1'b1;
    ovr <= 1'b0;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h41);
    repeat (4) @(posedge aclk);
    chk({31'h0, txd_out}, 32'h0);
    chk({31'h0, autobaud_rx}, 32'h0);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h141);
    repeat (4) @(posedge aclk);
    chk({31'h0, txd_out}, 32'h1);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h21);
    repeat (4) @(posedge aclk);
    chk({31'h0, async_rx_data}, 32'h1);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h281);
    repeat (4) @(posedge aclk);
    chk({30'h0, autobaud_rx, async_rx_data}, 32'h2);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h0);
    ovr_en <= 1'b0;
    $display("test echo done");
  endtask : t_echo
  task t_tx;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h8);
    fork
      axi_wr(ssb_pkg::OFS_TXBUF, 32'ha5);
      wait_irq(0, 10);
    join
    wait_irq(1, 2000);
    repeat (3) @(posedge aclk);
    chk({24'h0, dev_got}, 32'ha5);
    chk({30'h0, txd_out, rxd_out}, 32'h3);
    $display("test tx done");
  endtask : t_tx
  task t_rx;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h18);
    wait_irq(2, 2000);
    axi_rd(ssb_pkg::OFS_RXBUF, d, r);
    chk(d, 32'h3c);
    axi_rd(ssb_pkg::OFS_CTRL, d, r);
    chk(d, 32'h8);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h418);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h408);
    wait_irq(2, 2000);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h418);
    wait_irq(3, 2000);
    axi_rd(ssb_pkg::OFS_STAT, d, r);
    chk(d & 32'h7, 32'h5);
    $display("test rx done");
  endtask : t_rx
  task t_loop;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h20);
    axi_wr(ssb_pkg::OFS_TXBUF, 32'h5a);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h38);
    wait_irq(0, 40);
    @(posedge aclk);
    chk({31'h0, rxd_oe}, 32'h1);
    wait_irq(2, 2000);
    axi_rd(ssb_pkg::OFS_RXBUF, d, r);
    chk(d, 32'h5a);
    chk({24'h0, dev_got}, 32'h5a);
    $display("test loopback done");
  endtask : t_loop
  // Cycles between two baud clock pulses with reload zero
  task t_div(input logic [31:0] ctl, input int exp);
    int n;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h0);
    axi_wr(ssb_pkg::OFS_CTRL, ctl);
    wait_irq(4, 40);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (irqs[4] !== 1'b1 && n < 40);
    chk(n, exp);
    $display("test divider done");
  endtask : t_div
  task t_baud;
    axi_wr(ssb_pkg::OFS_CTRL, 32'h0);
    axi_wr(ssb_pkg::OFS_BAUD, 32'hffff);
    axi_rd(ssb_pkg::OFS_BAUD, d, r);
    chk(d, 32'h0);
    axi_wr(ssb_pkg::OFS_CTRL, 32'h8);
    axi_rd(ssb_pkg::OFS_BAUD, d, r);
    chk(d & 32'hffffe000, 32'h0);
    chk({31'h0, d > 32'h1f00}, 32'h1);
    $display("test baud done");
  endtask : t_baud
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_echo();
    t_tx();
    t_rx();
    t_loop();
    t_div(32'h8, ssb_pkg::SYNC_BAUD_DIV * ssb_pkg::PRESC_DIV_LO);
    t_div(32'h808, ssb_pkg::SYNC_BAUD_DIV * ssb_pkg::PRESC_DIV_HI);
    t_div(32'h1009, ssb_pkg::ASYNC_BAUD_DIV);
    t_baud();
    results();
  end
  initial
  begin
    #500000;
    bad_count++;
    results();
  end
endmodule : tb_ssb_serial
